// [logic/bsc_defs.svh]
// Purpose: constants for the branch and skip control block
// Assumes: 16-bit instruction words, 8-bit data, word-addressed program counter
// Notes:   opcode matches are mask/value pairs, except the two indirect forms, which match the whole word
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH
// ==========
// opcodes
`define BSC_OP_INDIRECT_JUMP          16'h9409
`define BSC_OP_INDIRECT_ROUTINE       16'h9509
`define BSC_MASK_REG_PAIR             16'hFC00
`define BSC_VAL_COMPARE_SKIP_EQ       16'h1000
`define BSC_VAL_COMPARE_REGS          16'h1400
`define BSC_VAL_COMPARE_CARRY         16'h0400
`define BSC_MASK_IMM                  16'hF000
`define BSC_VAL_COMPARE_IMM           16'h3000
`define BSC_MASK_REG_BIT              16'hFC08
`define BSC_VAL_REG_BIT_SKIP          16'hFC00
`define BSC_MASK_IO_BIT               16'hFD00
`define BSC_VAL_IO_BIT_SKIP           16'h9900
`define BSC_VAL_IO_BIT_WRITE          16'h9800
`define BSC_MASK_FLAG_BRANCH          16'hF800
`define BSC_VAL_FLAG_BRANCH           16'hF000
`define BSC_MASK_LONG_MEM             16'hFC0F
`define BSC_VAL_LONG_MEM              16'h9000
`define BSC_MASK_LONG_FLOW            16'hFE0C
`define BSC_VAL_LONG_FLOW             16'h940C
// ==========
// status flag positions
`define BSC_FLAG_C                    0
`define BSC_FLAG_Z                    1
`define BSC_FLAG_N                    2
`define BSC_FLAG_V                    3
`define BSC_FLAG_S                    3'd4
`define BSC_FLAG_H                    5
// ==========
// register port map
`define BSC_REG_CTRL                  3'h0
`define BSC_REG_FLAGS                 3'h1
`define BSC_REG_PC_LO                 3'h2
`define BSC_REG_PC_HI                 3'h3
`define BSC_REG_STATUS                3'h4
`define BSC_CTRL_RST                  8'h01
`define BSC_FLAGS_RST                 8'h00
`define BSC_PC_RST                    16'h0000
`define BSC_CTRL_RUN_BIT              0
// ==========
// extra stall cycles beyond the issue cycle, minus one
`define BSC_STALL_ONE                 2'h0
`define BSC_STALL_TWO                 2'h1
`endif

// [logic/bsc_pkg.sv]
// Purpose: shared types for the branch and skip control block
// Assumes: constants live in bsc_defs.svh
// Notes:   one-hot sequencer states
package bsc_pkg;
  typedef enum logic [3:0] {
    BSC_ST_READY   = 4'h1,
    BSC_ST_STALL   = 4'h2,
    BSC_ST_PUSH_LO = 4'h4,
    BSC_ST_PUSH_HI = 4'h8
  } bsc_state_e;
endpackage : bsc_pkg

// [logic/bsc_cmp_if.sv]
// Purpose: operands and flag results between sequencer and comparator
// Assumes: purely combinational path
// Notes:   chain selects the carry-in compare form
`timescale 1ns/1ps
interface bsc_cmp_if;
  logic [7:0] lhs;
  logic [7:0] rhs;
  logic       borrow_in;
  logic       zero_in;
  logic       chain;
  logic       c;
  logic       z;
  logic       n;
  logic       v;
  logic       h;
  modport requester (output lhs, rhs, borrow_in, zero_in, chain, input c, z, n, v, h);
  modport unit      (input lhs, rhs, borrow_in, zero_in, chain, output c, z, n, v, h);
endinterface : bsc_cmp_if

// [logic/bsc_cmp.sv]
// Purpose: subtract-only comparator producing flag values
// Assumes: difference itself is never stored
// Notes:   chained form keeps zero only if it was already set
`timescale 1ns/1ps
module bsc_cmp (
  bsc_cmp_if.unit cmp
);
  logic [7:0] diff;
  always_comb
  begin
    diff  = cmp.lhs - cmp.rhs - {7'h00, cmp.borrow_in};
    cmp.h = (~cmp.lhs[3] & cmp.rhs[3]) | (cmp.rhs[3] & diff[3]) | (diff[3] & ~cmp.lhs[3]);
    cmp.c = (~cmp.lhs[7] & cmp.rhs[7]) | (cmp.rhs[7] & diff[7]) | (diff[7] & ~cmp.lhs[7]);
    cmp.v = (cmp.lhs[7] & ~cmp.rhs[7] & ~diff[7]) | (~cmp.lhs[7] & cmp.rhs[7] & diff[7]);
    cmp.n = diff[7];
    // chained form keeps a nonzero low byte visible
    cmp.z = (diff == 8'h00) & (~cmp.chain | cmp.zero_in);
  end
endmodule : bsc_cmp

// [logic/bsc_len.sv]
// Purpose: tells whether an instruction word opens a two-word instruction
// Assumes: only long memory access and long jump/call forms are two words
// Notes:   used to size a skip
`timescale 1ns/1ps
`include "bsc_defs.svh"
module bsc_len (
  input  wire logic [15:0] word_in,
  output logic             two_word_out
);
  assign two_word_out = ((word_in & `BSC_MASK_LONG_MEM) == `BSC_VAL_LONG_MEM)
                      | ((word_in & `BSC_MASK_LONG_FLOW) == `BSC_VAL_LONG_FLOW);
endmodule : bsc_len

// [logic/bsc_core.sv]
// Purpose: control-flow execution: indirect jump/call, compares, skips,
//          flag branches, single-bit I/O set and clear
// Assumes: operands and I/O read data arrive in the issue cycle from
//          same-clock logic; other instructions just advance the pc by one
// Notes:   issue is a valid/ready handshake; multi-cycle forms drop ready
`timescale 1ns/1ps
`include "bsc_defs.svh"
//
// Contract
// - indirect jump loads Z, flags kept, two cycles
// - indirect call pushes return, loads Z, four cycles
// - equal registers skip next, one to three cycles
// - compares set Z N V C H only
// - register bit skip on clear or set
// - I/O bit skip on clear or set
// - flag branch on selected bit polarity
// - signed branches use N xor V
// - unsigned branches use carry
// - carry branches on carry polarity
// - half-carry branches on H polarity
// - transfer-bit branches on T polarity
// - overflow branches on V polarity
// - interrupt-state branches on I polarity
// - I/O bit set or clear, two cycles
module bsc_core
  import bsc_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        instr_valid_in,
  input  wire logic [15:0] instr_in,
  input  wire logic [15:0] instr_next_in,
  output logic             instr_ready_out,
  output logic      [4:0]  rd_sel_out,
  output logic      [4:0]  rr_sel_out,
  input  wire logic [7:0]  rd_data_in,
  input  wire logic [7:0]  rr_data_in,
  input  wire logic [15:0] z_ptr_in,
  output logic      [4:0]  io_addr_out,
  input  wire logic [7:0]  io_rdata_in,
  output logic      [7:0]  io_wdata_out,
  output logic             io_we_out,
  output logic             push_out,
  output logic      [7:0]  push_data_out,
  input  wire logic        flags_load_in,
  input  wire logic [7:0]  flags_data_in,
  output logic      [7:0]  status_flags_out,
  output logic      [15:0] pc_out,
  output logic             redirect_out
);
  // ==========
  // state
  bsc_state_e  state_q, state_d;
  logic [1:0]  stall_q, stall_d;
  logic [15:0] pc_q, pc_d;
  logic [15:0] ret_q, ret_d;
  logic [7:0]  status_flags_register_q, status_flags_register_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  rdata_q, rdata_d;
  logic [7:0]  io_wdata_q, io_wdata_d;
  logic [4:0]  io_addr_q, io_addr_d;
  logic        io_we_q, io_we_d;
  logic        push_q, push_d;
  logic [7:0]  push_data_q, push_data_d;
  logic        redirect_q, redirect_d;
  logic        taken_q, taken_d;
  logic        skip_q, skip_d;

  // ==========
  // decode
  logic        issue;
  logic        is_ijump, is_indirect_routine_invoke, is_compare_then_skip_equal, is_cp, is_cpc, is_cpi;
  logic        is_rbit, is_iobit, is_iowr, is_branch;
  logic        next_two;
  logic        cond_bit;
  logic        skip_cond;
  logic [7:0]  bit_mask;
  logic [15:0] pc_inc;
  logic [15:0] br_offset;

  bsc_cmp_if cmp_bus ();

  bsc_cmp u_cmp (
    .cmp (cmp_bus)
  );

  bsc_len u_len (
    .word_in      (instr_next_in),
    .two_word_out (next_two)
  );

  assign instr_ready_out = ctrl_q[`BSC_CTRL_RUN_BIT] & (state_q == BSC_ST_READY);
  assign issue           = instr_ready_out & instr_valid_in;

  always_comb
  begin
    is_ijump  = instr_in == `BSC_OP_INDIRECT_JUMP;
    is_indirect_routine_invoke  = instr_in == `BSC_OP_INDIRECT_ROUTINE;
    is_compare_then_skip_equal   = (instr_in & `BSC_MASK_REG_PAIR) == `BSC_VAL_COMPARE_SKIP_EQ;
    is_cp     = (instr_in & `BSC_MASK_REG_PAIR) == `BSC_VAL_COMPARE_REGS;
    is_cpc    = (instr_in & `BSC_MASK_REG_PAIR) == `BSC_VAL_COMPARE_CARRY;
    is_cpi    = (instr_in & `BSC_MASK_IMM) == `BSC_VAL_COMPARE_IMM;
    is_rbit   = (instr_in & `BSC_MASK_REG_BIT) == `BSC_VAL_REG_BIT_SKIP;
    is_iobit  = (instr_in & `BSC_MASK_IO_BIT) == `BSC_VAL_IO_BIT_SKIP;
    is_iowr   = (instr_in & `BSC_MASK_IO_BIT) == `BSC_VAL_IO_BIT_WRITE;
    is_branch = (instr_in & `BSC_MASK_FLAG_BRANCH) == `BSC_VAL_FLAG_BRANCH;
  end

  // immediate compare reaches only the upper sixteen registers
  assign rd_sel_out  = is_cpi ? {1'b1, instr_in[7:4]} : instr_in[8:4];
  assign rr_sel_out  = {instr_in[9], instr_in[3:0]};
  assign io_addr_out = (state_q == BSC_ST_READY) ? instr_in[7:3] : io_addr_q;
  assign bit_mask    = 8'h01 << instr_in[2:0];
  assign pc_inc      = pc_q + 16'h0001;
  assign br_offset   = {{9{instr_in[9]}}, instr_in[9:3]};

  // s = 4 is evaluated as N xor V, since compares leave S alone
  always_comb
  begin
    if (instr_in[2:0] == `BSC_FLAG_S)
      cond_bit = status_flags_register_q[`BSC_FLAG_N]
               ^ status_flags_register_q[`BSC_FLAG_V];
    else
      cond_bit = status_flags_register_q[instr_in[2:0]];
  end

  always_comb
  begin
    skip_cond = 1'b0;
    if (is_compare_then_skip_equal)
      skip_cond = rd_data_in == rr_data_in;
    else if (is_rbit)
      skip_cond = rd_data_in[instr_in[2:0]] == instr_in[9];
    else if (is_iobit)
      skip_cond = io_rdata_in[instr_in[2:0]] == instr_in[9];
  end

  always_comb
  begin
    cmp_bus.lhs       = rd_data_in;
    cmp_bus.rhs       = is_cpi ? {instr_in[11:8], instr_in[3:0]} : rr_data_in;
    cmp_bus.borrow_in = is_cpc & status_flags_register_q[`BSC_FLAG_C];
    cmp_bus.zero_in   = status_flags_register_q[`BSC_FLAG_Z];
    cmp_bus.chain     = is_cpc;
  end

  // ==========
  // sequencer and datapath next values
  always_comb
  begin
    state_d                 = state_q;
    stall_d                 = stall_q;
    pc_d                    = pc_q;
    ret_d                   = ret_q;
    status_flags_register_d = status_flags_register_q;
    ctrl_d                  = ctrl_q;
    io_wdata_d              = io_wdata_q;
    io_addr_d               = io_addr_q;
    io_we_d                 = 1'b0;
    push_d                  = 1'b0;
    push_data_d             = push_data_q;
    redirect_d              = 1'b0;
    taken_d                 = taken_q;
    skip_d                  = skip_q;

    // lowest priority: software, then the surrounding core, then compares
    if (reg_wr_in && reg_addr_in == `BSC_REG_FLAGS)
      status_flags_register_d = reg_wdata_in;
    if (flags_load_in)
      status_flags_register_d = flags_data_in;
    if (reg_wr_in && reg_addr_in == `BSC_REG_CTRL)
      ctrl_d = reg_wdata_in;
    if (reg_wr_in && reg_addr_in == `BSC_REG_PC_LO)
      pc_d[7:0] = reg_wdata_in;
    if (reg_wr_in && reg_addr_in == `BSC_REG_PC_HI)
      pc_d[15:8] = reg_wdata_in;

    case (state_q)
      BSC_ST_READY:
      begin
        if (issue)
        begin
          pc_d    = pc_inc;
          taken_d = 1'b0;
          skip_d  = 1'b0;
          if (is_ijump)
          begin
            pc_d       = z_ptr_in;
            redirect_d = 1'b1;
            state_d    = BSC_ST_STALL;
            stall_d    = `BSC_STALL_ONE;
          end
          else if (is_indirect_routine_invoke)
          begin
            pc_d        = z_ptr_in;
            ret_d       = pc_inc;
            redirect_d  = 1'b1;
            push_d      = 1'b1;
            push_data_d = pc_inc[7:0];
            state_d     = BSC_ST_PUSH_LO;
          end
          else if (is_cp || is_cpc || is_cpi)
          begin
            status_flags_register_d[`BSC_FLAG_C] = cmp_bus.c;
            status_flags_register_d[`BSC_FLAG_Z] = cmp_bus.z;
            status_flags_register_d[`BSC_FLAG_N] = cmp_bus.n;
            status_flags_register_d[`BSC_FLAG_V] = cmp_bus.v;
            status_flags_register_d[`BSC_FLAG_H] = cmp_bus.h;
          end
          else if ((is_compare_then_skip_equal || is_rbit || is_iobit) && skip_cond)
          begin
            skip_d     = 1'b1;
            redirect_d = 1'b1;
            state_d    = BSC_ST_STALL;
            // skipping a two-word instruction costs one more cycle
            if (next_two)
            begin
              pc_d    = pc_q + 16'h0003;
              stall_d = `BSC_STALL_TWO;
            end
            else
            begin
              pc_d    = pc_q + 16'h0002;
              stall_d = `BSC_STALL_ONE;
            end
          end
          else if (is_branch && (cond_bit ^ instr_in[10]))
          begin
            pc_d       = pc_inc + br_offset;
            taken_d    = 1'b1;
            redirect_d = 1'b1;
            state_d    = BSC_ST_STALL;
            stall_d    = `BSC_STALL_ONE;
          end
          else if (is_iowr)
          begin
            // whole-byte rewrite: set flags of clear-on-one bits get cleared
            io_addr_d  = instr_in[7:3];
            io_wdata_d = instr_in[9] ? (io_rdata_in | bit_mask)
                                     : (io_rdata_in & ~bit_mask);
            io_we_d    = 1'b1;
            state_d    = BSC_ST_STALL;
            stall_d    = `BSC_STALL_ONE;
          end
        end
      end
      BSC_ST_PUSH_LO:
      begin
        push_d      = 1'b1;
        push_data_d = ret_q[15:8];
        state_d     = BSC_ST_PUSH_HI;
      end
      BSC_ST_PUSH_HI:
      begin
        state_d = BSC_ST_STALL;
        stall_d = `BSC_STALL_ONE;
      end
      BSC_ST_STALL:
      begin
        if (stall_q == `BSC_STALL_ONE)
          state_d = BSC_ST_READY;
        else
          stall_d = stall_q - 2'h1;
      end
      default:
      begin
        state_d = BSC_ST_READY;
      end
    endcase
  end

  // ==========
  // register port read
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `BSC_REG_CTRL:   rdata_d = ctrl_q;
        `BSC_REG_FLAGS:  rdata_d = status_flags_register_q;
        `BSC_REG_PC_LO:  rdata_d = pc_q[7:0];
        `BSC_REG_PC_HI:  rdata_d = pc_q[15:8];
        `BSC_REG_STATUS: rdata_d = {5'h00, skip_q, taken_q, state_q != BSC_ST_READY};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  // ==========
  // registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q                 <= BSC_ST_READY;
      stall_q                 <= `BSC_STALL_ONE;
      pc_q                    <= `BSC_PC_RST;
      ret_q                   <= `BSC_PC_RST;
      status_flags_register_q <= `BSC_FLAGS_RST;
      ctrl_q                  <= `BSC_CTRL_RST;
      rdata_q                 <= 8'h00;
      io_wdata_q              <= 8'h00;
      io_addr_q               <= 5'h00;
      io_we_q                 <= 1'b0;
      push_q                  <= 1'b0;
      push_data_q             <= 8'h00;
      redirect_q              <= 1'b0;
      taken_q                 <= 1'b0;
      skip_q                  <= 1'b0;
    end
    else
    begin
      state_q                 <= state_d;
      stall_q                 <= stall_d;
      pc_q                    <= pc_d;
      ret_q                   <= ret_d;
      status_flags_register_q <= status_flags_register_d;
      ctrl_q                  <= ctrl_d;
      rdata_q                 <= rdata_d;
      io_wdata_q              <= io_wdata_d;
      io_addr_q               <= io_addr_d;
      io_we_q                 <= io_we_d;
      push_q                  <= push_d;
      push_data_q             <= push_data_d;
      redirect_q              <= redirect_d;
      taken_q                 <= taken_d;
      skip_q                  <= skip_d;
    end
  end

  assign reg_rdata_out    = rdata_q;
  assign io_wdata_out     = io_wdata_q;
  assign io_we_out        = io_we_q;
  assign push_out         = push_q;
  assign push_data_out    = push_data_q;
  assign status_flags_out = status_flags_register_q;
  assign pc_out           = pc_q;
  assign redirect_out     = redirect_q;
endmodule : bsc_core

// [tb/bsc_core_props.sv]
// Purpose: port-level properties of bsc_core
// Assumes: one clock, asynchronous active-low reset
// Notes:   run bit assumed set
`timescale 1ns/1ps
`include "bsc_defs.svh"
module bsc_core_props import bsc_pkg::*; (
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  input wire logic [2:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        instr_valid_in,
  input wire logic [15:0] instr_in,
  input wire logic [15:0] instr_next_in,
  input wire logic        instr_ready_out,
  input wire logic [7:0]  rd_data_in,
  input wire logic [7:0]  rr_data_in,
  input wire logic [15:0] z_ptr_in,
  input wire logic [4:0]  io_addr_out,
  input wire logic [7:0]  io_rdata_in,
  input wire logic [7:0]  io_wdata_out,
  input wire logic        io_we_out,
  input wire logic        push_out,
  input wire logic [7:0]  push_data_out,
  input wire logic        flags_load_in,
  input wire logic [7:0]  status_flags_out,
  input wire logic [15:0] pc_out,
  input wire logic        redirect_out
);
  // ==========
  // decode helpers
  logic        iss, ij, ic, cp, br, eqs, sk, hit, two, iow, tkn, nf, bitv;
  logic [7:0]  mask, iov;
  logic [4:0]  ioa;
  logic [15:0] tgt;
  always_comb
  begin
    iss  = instr_valid_in && instr_ready_out;
    ij   = instr_in == `BSC_OP_INDIRECT_JUMP;
    ic   = instr_in == `BSC_OP_INDIRECT_ROUTINE;
    cp   = (instr_in & `BSC_MASK_REG_PAIR) == `BSC_VAL_COMPARE_REGS;
    br   = (instr_in & `BSC_MASK_FLAG_BRANCH) == `BSC_VAL_FLAG_BRANCH;
    iow  = (instr_in & `BSC_MASK_IO_BIT) == `BSC_VAL_IO_BIT_WRITE;
    eqs  = (instr_in & `BSC_MASK_REG_PAIR) == `BSC_VAL_COMPARE_SKIP_EQ;
    bitv = rd_data_in[instr_in[2:0]];
    if ((instr_in & `BSC_MASK_IO_BIT) == `BSC_VAL_IO_BIT_SKIP)
      bitv = io_rdata_in[instr_in[2:0]];
    hit  = eqs ? rd_data_in == rr_data_in : bitv == instr_in[9];
    sk   = eqs || (instr_in & `BSC_MASK_REG_BIT) == `BSC_VAL_REG_BIT_SKIP
        || (instr_in & `BSC_MASK_IO_BIT) == `BSC_VAL_IO_BIT_SKIP;
    two  = (instr_next_in & `BSC_MASK_LONG_MEM) == `BSC_VAL_LONG_MEM
        || (instr_next_in & `BSC_MASK_LONG_FLOW) == `BSC_VAL_LONG_FLOW;
    tkn  = status_flags_out[instr_in[2:0]];
    if (instr_in[2:0] == `BSC_FLAG_S)
      tkn = status_flags_out[`BSC_FLAG_N] ^ status_flags_out[`BSC_FLAG_V];
    tkn  = tkn ^ instr_in[10];
    tgt  = pc_out + 16'h0001 + {{9{instr_in[9]}}, instr_in[9:3]};
    mask = 8'h01 << instr_in[2:0];
    iov  = instr_in[9] ? io_rdata_in | mask : io_rdata_in & ~mask;
    ioa  = instr_in[7:3];
    // external flag loads may change flags
    nf   = !flags_load_in && !(reg_wr_in && reg_addr_in == `BSC_REG_FLAGS)
        && (ij || ic || br || sk || iow);
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // ==========
  // properties
  property p_indirect_jump;
    iss && ij |=> pc_out == $past(z_ptr_in) && redirect_out && !instr_ready_out
      ##1 instr_ready_out;
  endproperty
  a_indirect_jump: assert property (p_indirect_jump) else $error("indirect jump wrong");
  property p_indirect_routine_invoke;
    iss && ic |=> pc_out == $past(z_ptr_in) && push_out && !instr_ready_out
      && push_data_out == 8'($past(pc_out) + 16'h0001)
      ##1 push_out && !instr_ready_out
      && push_data_out == 8'(($past(pc_out, 2) + 16'h0001) >> 8)
      ##1 !instr_ready_out ##1 instr_ready_out;
  endproperty
  a_indirect_routine_invoke: assert property (p_indirect_routine_invoke) else $error("indirect call wrong");
  property p_cmp;
    iss && cp |=> status_flags_out[1] == ($past(rd_data_in) == $past(rr_data_in))
      && status_flags_out[0] == ($past(rd_data_in) < $past(rr_data_in))
      && (status_flags_out & 8'hD0) == ($past(status_flags_out) & 8'hD0)
      && pc_out == $past(pc_out) + 16'h0001;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flags wrong");
  property p_keep;
    iss && nf |=> $stable(status_flags_out);
  endproperty
  a_keep: assert property (p_keep) else $error("flags changed");
  property p_br_hit;
    iss && br && tkn |=> pc_out == $past(tgt) && redirect_out && !instr_ready_out
      ##1 instr_ready_out;
  endproperty
  a_br_hit: assert property (p_br_hit) else $error("taken branch wrong");
  property p_br_miss;
    iss && br && !tkn |=> pc_out == $past(pc_out) + 16'h0001 && instr_ready_out;
  endproperty
  a_br_miss: assert property (p_br_miss) else $error("untaken branch wrong");
  property p_skip1;
    iss && sk && hit && !two |=> pc_out == $past(pc_out) + 16'h0002 && redirect_out
      && !instr_ready_out ##1 instr_ready_out;
  endproperty
  a_skip1: assert property (p_skip1) else $error("short skip wrong");
  property p_skip2;
    iss && sk && hit && two |=> pc_out == $past(pc_out) + 16'h0003 && redirect_out
      && !instr_ready_out ##1 !instr_ready_out ##1 instr_ready_out;
  endproperty
  a_skip2: assert property (p_skip2) else $error("long skip wrong");
  property p_noskip;
    iss && sk && !hit |=> pc_out == $past(pc_out) + 16'h0001 && instr_ready_out;
  endproperty
  a_noskip: assert property (p_noskip) else $error("skip without cause");
  property p_iow;
    iss && iow |=> io_we_out && io_wdata_out == $past(iov) && io_addr_out == $past(ioa)
      && !instr_ready_out ##1 instr_ready_out && !io_we_out;
  endproperty
  a_iow: assert property (p_iow) else $error("bit write wrong");
  c_br: cover property (iss && br && tkn);
  c_skip2: cover property (iss && sk && hit && two);
  c_indirect_routine_invoke: cover property (iss && ic);
endmodule : bsc_core_props
bind bsc_core bsc_core_props i_props (.*);

// [tb/branch_skip_control_test.sv]
// Purpose: self-checking bench for bsc_core
// Assumes: bench plays register file, I/O space and software port
// Notes:   driver queues expectations, monitor checks them
`timescale 1ns/1ps
`include "bsc_defs.svh"
module branch_skip_control_test import bsc_pkg::*;;
  logic        sys_clk_in = 1'b0, reset_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic        instr_valid_in = 1'b0, flags_load_in = 1'b0;
  logic [2:0]  reg_addr_in = 3'h0;
  logic [7:0]  reg_wdata_in = 8'h00, rd_data_in = 8'h00, rr_data_in = 8'h00;
  logic [7:0]  io_rdata_in = 8'h00, flags_data_in = 8'h00;
  logic [15:0] instr_in = 16'h0000, instr_next_in = 16'h0000, z_ptr_in = 16'h0000;
  logic [7:0]  reg_rdata_out, io_wdata_out, push_data_out, status_flags_out;
  logic [4:0]  rd_sel_out, rr_sel_out, io_addr_out;
  logic        instr_ready_out, io_we_out, push_out, redirect_out, iss_q, rd_q, t, pol, two;
  logic [15:0] pc_out, pc_m, p, i;
  logic [7:0]  fl_m, d, r, v, k, cy_e;
  logic [15:0] q_pc[$], q_io[$];
  logic [7:0]  q_fl[$], q_rd[$], q_push[$], q_cy[$];
  logic [31:0] lfsr_q = 32'h10A6;
  logic        busy = 1'b0;
  int          num_errors = 0, cmp_count = 0, cnt = 0, c;
  logic [15:0] base [3] = '{16'h1000, 16'hFC00, 16'h9900};
  bsc_core i_dut (.*);
  // ==========
  // helpers
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction : rnd
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp16
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp16({8'h00, g}, {8'h00, e});
  endtask : cmp8
  function automatic logic [7:0] fcmp(input logic [7:0] a, b, f, input logic ch);
    logic [7:0] x;
    logic [7:0] o;
    x = a - b - {7'h00, ch & f[0]};
    o = f;
    o[0] = (~a[7] & b[7]) | (b[7] & x[7]) | (x[7] & ~a[7]);
    o[1] = (x == 8'h00) & (~ch | f[1]);
    o[2] = x[7];
    o[3] = (a[7] & ~b[7] & ~x[7]) | (~a[7] & b[7] & x[7]);
    o[5] = (~a[3] & b[3]) | (b[3] & x[3]) | (x[3] & ~a[3]);
    return o;
  endfunction : fcmp
  // one-cycle forms keep valid up
  task automatic issue(input logic [15:0] ins, nx, input logic [7:0] a, b,
                       input logic [15:0] pe, input logic [7:0] fe, input int n);
    instr_in <= ins;
    instr_next_in <= nx;
    rd_data_in <= a;
    rr_data_in <= b;
    io_rdata_in <= a;
    instr_valid_in <= 1'b1;
    q_pc.push_back(pe);
    q_fl.push_back(fe);
    q_cy.push_back(8'(n));
    @(posedge sys_clk_in);
    if (n > 1) instr_valid_in <= 1'b0;
    repeat (n - 1) @(posedge sys_clk_in);
    pc_m = pe;
    fl_m = fe;
  endtask : issue
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] w);
    reg_addr_in <= a;
    reg_wdata_in <= w;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    q_rd.push_back(e);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : reg_rd
  task automatic ld_flags(input logic [7:0] f);
    instr_valid_in <= 1'b0;
    flags_data_in <= f;
    flags_load_in <= 1'b1;
    @(posedge sys_clk_in);
    flags_load_in <= 1'b0;
  endtask : ld_flags
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // ==========
  // clock, monitor, watchdog
  initial
  begin
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    iss_q <= instr_valid_in & instr_ready_out;
    rd_q <= reg_rd_in;
  end
  always @(negedge sys_clk_in)
  begin
    if (rd_q === 1'b1) cmp8(reg_rdata_out, q_rd.pop_front());
    if (io_we_out === 1'b1) cmp16({3'h0, io_addr_out, io_wdata_out}, q_io.pop_front());
    if (push_out === 1'b1) cmp8(push_data_out, q_push.pop_front());
    if (iss_q === 1'b1)
    begin
      cmp16(pc_out, q_pc.pop_front());
      cmp8(status_flags_out, q_fl.pop_front());
      cy_e = q_cy.pop_front();
      busy = 1'b1;
      cnt = 0;
    end
    if (busy) cnt++;
    if (busy && instr_ready_out === 1'b1)
    begin
      cmp8(cnt[7:0], cy_e);
      busy = 1'b0;
    end
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    num_errors++;
    end_sim();
  end
  // ==========
  // main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd(`BSC_REG_CTRL, `BSC_CTRL_RST);
    reg_rd(`BSC_REG_FLAGS, `BSC_FLAGS_RST);
    reg_rd(`BSC_REG_STATUS, 8'h00);
    reg_wr(3'h7, 8'hFF);
    reg_rd(3'h7, 8'h00);
    reg_wr(`BSC_REG_FLAGS, 8'hA5);
    reg_rd(`BSC_REG_FLAGS, 8'hA5);
    reg_wr(`BSC_REG_PC_LO, 8'h34);
    reg_wr(`BSC_REG_PC_HI, 8'h12);
    // stopped core must ignore an offered instruction
    reg_wr(`BSC_REG_CTRL, 8'h00);
    instr_valid_in <= 1'b1;
    reg_rd(`BSC_REG_PC_LO, 8'h34);
    instr_valid_in <= 1'b0;
    reg_wr(`BSC_REG_CTRL, 8'h01);
    pc_m = 16'h1234;
    fl_m = 8'hA5;
    for (int j = 0; j < 48; j++)
    begin
      v = rnd();
      k = rnd();
      ld_flags(v);
      t = ((j[2:0] == `BSC_FLAG_S) ? v[2] ^ v[3] : v[j[2:0]]) ^ j[3];
      p = pc_m + 16'h0001 + (t ? {{9{k[6]}}, k[6:0]} : 16'h0000);
      issue({5'h1E, j[3], k[6:0], j[2:0]}, 16'h0000, 8'h00, 8'h00, p, v, t ? 2 : 1);
    end
    for (int j = 0; j < 12; j++)
    begin
      v = rnd();
      d = rnd();
      r = rnd();
      if (j[1:0] == 2'd0) r = d;
      ld_flags(v);
      i = (j % 3 == 0) ? 16'h1401 : (j % 3 == 1) ? 16'h0401 : {4'h3, r[7:4], 4'h0, r[3:0]};
      issue(i, 16'h0000, d, r, pc_m + 16'h0001, fcmp(d, r, v, j % 3 == 1), 1);
    end
    for (int j = 0; j < 24; j++)
    begin
      d = rnd();
      r = rnd();
      pol = j[0];
      two = j[1];
      i = base[j % 3] | {6'h00, pol, 6'h00, r[2:0]};
      if (j % 3 == 2) i[7:3] = r[7:3];
      if (j % 3 == 0) r = pol ? d : ~d;
      t = (j % 3 == 0) ? d == r : d[r[2:0]] == pol;
      c = t ? (two ? 3 : 2) : 1;
      issue(i, two ? 16'h940C : 16'h0000, d, r, pc_m + 16'(c), fl_m, c);
    end
    for (int j = 0; j < 4; j++)
    begin
      d = rnd();
      r = rnd();
      v = 8'h01 << r[2:0];
      q_io.push_back({3'h0, r[7:3], j[0] ? d | v : d & ~v});
      issue({6'h26, j[0], 1'b0, r[7:0]}, 16'h0000, d, d, pc_m + 16'h0001, fl_m, 2);
    end
    d = rnd();
    r = rnd();
    z_ptr_in <= {d, r};
    issue(`BSC_OP_INDIRECT_JUMP, 16'h0000, d, r, {d, r}, fl_m, 2);
    p = pc_m + 16'h0001;
    q_push.push_back(p[7:0]);
    q_push.push_back(p[15:8]);
    z_ptr_in <= {r, d};
    issue(`BSC_OP_INDIRECT_ROUTINE, 16'h0000, d, r, {r, d}, fl_m, 4);
    reg_rd(`BSC_REG_PC_LO, d);
    repeat (4) @(posedge sys_clk_in);
    cmp16(16'(q_pc.size() + q_io.size() + q_push.size() + q_rd.size()), 16'h0000);
    end_sim();
  end
endmodule : branch_skip_control_test
